// ### hdl/fault_pkg.sv
// Constants and carrier types shared by the disc drive fault supervisor.
package fault_pkg;

    // ------------------------------------------------------------
    // Address limits
    // ------------------------------------------------------------
    localparam logic [9:0] CYL_MAX  = 10'h336;
    localparam logic [3:0] HEAD_MAX = 4'h8;
    localparam logic [7:0] SECT_MAX = 8'h3f;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TCC_HZ   = 135;
    localparam int SEEK_MS  = 120;
    localparam int LONG_MS  = 1667;
    localparam int TO_CNT_W = 8;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 5;
    localparam logic [4:0]  REG_STATUS = 5'h00;
    localparam logic [4:0]  REG_ADDR   = 5'h04;
    localparam logic [4:0]  REG_CTRL   = 5'h08;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int ST_ILL_HEAD  = 0;
    localparam int ST_ILL_SECT  = 1;
    localparam int ST_SEEK_CHK  = 2;
    localparam int ST_CYL_OVER  = 3;
    localparam int ST_DRV_FAULT = 4;
    localparam int ST_GAIN      = 5;
    localparam int ST_CARR_BACK = 6;
    localparam int ST_TIMEOUT   = 7;
    localparam int ST_INTERLOCK = 8;
    localparam int ST_READY     = 9;
    localparam int ST_TIMING    = 10;
    localparam int AD_HEAD_LSB  = 16;
    localparam int AD_SECT_LSB  = 24;
    localparam int CTRL_CLEAR   = 0;
    localparam int CTRL_UNLOAD  = 1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_RETRACT, SEQ_HELD, SEQ_BRAKE, SEQ_UNLOCK
    } seq_t;

    typedef struct packed {
        logic seek_decoded;
        logic address_command;
        logic sector_transfer_command;
        logic recalibrate_command;
        logic clear_status_command;
        logic home_seek_n;
    } cmd_t;

    typedef struct packed {
        logic board_seated;
        logic chamber_connected;
        logic supply_good;
        logic heatsink_ok;
        logic spindle_fault;
    } ilk_t;

    typedef struct packed {
        logic timeout_fault_indicator_n;
        logic drive_fault_lamp_n;
        logic ready_lamp_n;
        logic servo_enable_n;
        logic head_retract;
        logic spindle_stop_n;
        logic door_unlock;
        logic door_unlocked_lamp_n;
        logic gain_fault_indicator_n;
        logic carriage_back_indicator_n;
        logic interlock_lamp_n;
        logic seek_check;
    } ind_t;

    typedef struct packed {
        cmd_t                cmd_prev;
        logic                tcc_prev;
        logic [9:0]          seek_check_clear_pulse;
        logic [3:0]          head;
        logic [7:0]          sector;
        logic                seek_chk;
        logic                ill_head;
        logic                ill_sect;
        logic                gain_f;
        logic                cb_f;
        logic                ilk_f;
        logic                to_f;
        logic                to_act;
        logic                to_long;
        logic                to_unload;
        logic [TO_CNT_W-1:0] to_cnt;
        logic                drive_ready_flag;
        logic                servo_en;
        seq_t                seq;
        ind_t                ind;
        logic                sw_clear;
        logic                sw_unload;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        logic [ADDR_W-1:0]   waddr;
        logic [1:0]          wdata;
        logic                wstb;
    } state_t;

    localparam cmd_t CMD_RST = '{home_seek_n: 1'b1, default: 1'b0};
    localparam ind_t IND_RST = '{head_retract: 1'b0, door_unlock: 1'b0,
                                 seek_check: 1'b0, default: 1'b1};
    localparam state_t STATE_RST = '{cmd_prev: CMD_RST, seq: SEQ_IDLE, ind: IND_RST,
                                     awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                     default: '0};

endpackage

// ### hdl/disc_fault_supervisor.sv
// Fault supervision for a moving-head disc drive with an AXI4-Lite status port.
//
// Operation
// RULE1 - Cylinder above 822 flagged and not loaded
// RULE2 - Seek edge sets check on range or motion
// RULE3 - Any illegal address shows as status bit 2
// RULE4 - Home seek or legal seek clears check
// RULE5 - Non-destructive reset clears the recoverable flags
// RULE6 - Head above 8 flagged, head register kept
// RULE7 - Sector above 63 flagged, sector kept
// RULE8 - Seek starts 120 ms timeout until settled
// RULE9 - Timeout counter steps on spindle-derived clock
// RULE10 - Load, unload, recalibrate start 1667 ms timeout
// RULE11 - Expiry lights indicator, freezes counter, full shutdown
// RULE12 - Only destructive reset clears the timeout
// RULE13 - Unload: lamp, bit 4, retract, ready, servo off (code: lamp and bit 4 only on a fault, not on a CTRL_UNLOAD write)
// RULE14 - Retracted: stop spindle, then unlock door (code: only on timeout or interlock fault, else held with spindle on)
// RULE15 - Gain loss while ready sets gain fault
// RULE16 - Gain fault clears on non-destructive reset
// RULE17 - Carriage back while ready sets fault
// RULE18 - Carriage back fault clears only destructively
// RULE19 - Any bad interlock input declares interlock fault
// RULE20 - Counter restarts and compares against window ends
module disc_fault_supervisor #(
    parameter int TCC_HZ  = fault_pkg::TCC_HZ,
    parameter int SEEK_MS = fault_pkg::SEEK_MS,
    parameter int LONG_MS = fault_pkg::LONG_MS
) (
    // Clock, reset, enable
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         ce_i,
    // Internal control bus
    input  wire fault_pkg::cmd_t              cmd_i,
    input  wire logic [15:0]                  bus_data_i,
    // Servo, spindle and interlock inputs
    input  wire logic                         heads_settled_n_i,
    input  wire logic                         timeout_count_clock_i,
    input  wire logic                         servo_gain_ok_i,
    input  wire logic                         carriage_fully_back_i,
    input  wire logic                         spindle_turning_n_i,
    input  wire logic                         interlock_clear_i,
    input  wire logic                         run_switch_i,
    input  wire fault_pkg::ilk_t              ilk_i,
    // Indicators and actuators
    output fault_pkg::ind_t                   ind_o,
    // AXI4-Lite slave
    input  wire logic [fault_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [fault_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);

    // ------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------
    // A longest time rounds down to whole spindle-clock periods.
    localparam int SEEK_TICKS = SEEK_MS * TCC_HZ / 1000;
    localparam int LONG_TICKS = LONG_MS * TCC_HZ / 1000;
    localparam logic [fault_pkg::TO_CNT_W-1:0] SEEK_LIM =
        fault_pkg::TO_CNT_W'(SEEK_TICKS);
    localparam logic [fault_pkg::TO_CNT_W-1:0] LONG_LIM =
        fault_pkg::TO_CNT_W'(LONG_TICKS);

    if (SEEK_TICKS < 1 || LONG_TICKS >= (1 << fault_pkg::TO_CNT_W)) begin : g_bad_timing
        $error("Timeout windows do not fit the counter.");
    end

    function automatic logic [1:0] reg_sel(input logic [fault_pkg::ADDR_W-1:0] a);
        unique case (a)
            fault_pkg::REG_STATUS: reg_sel = 2'h0;
            fault_pkg::REG_ADDR:   reg_sel = 2'h1;
            fault_pkg::REG_CTRL:   reg_sel = 2'h2;
            default:               reg_sel = 2'h3;
        endcase
    endfunction

    fault_pkg::state_t q;
    fault_pkg::state_t d;

    logic        seek_e;
    logic        addr_e;
    logic        sect_e;
    logic        recal_e;
    logic        home_e;
    logic        tcc_e;
    logic        cylinder_over_range;
    logic        head_bad;
    logic        sect_bad;
    logic        seek_bad;
    logic        seek_ok;
    logic        nd_rst;
    logic        d_rst;
    logic        gain_set;
    logic        cb_set;
    logic        ilk_bad;
    logic        trig;
    logic        full;
    logic        unload_start;
    logic        cancel;
    logic        expire;
    logic [fault_pkg::TO_CNT_W-1:0] limit;
    logic [15:0] status_w;
    logic [31:0] addr_w;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        seek_e  = cmd_i.seek_decoded & ~q.cmd_prev.seek_decoded;
        addr_e  = cmd_i.address_command & ~q.cmd_prev.address_command;
        sect_e  = addr_e | (cmd_i.sector_transfer_command
                            & ~q.cmd_prev.sector_transfer_command);
        recal_e = cmd_i.recalibrate_command & ~q.cmd_prev.recalibrate_command;
        home_e  = ~cmd_i.home_seek_n & q.cmd_prev.home_seek_n;
        // The count clock is slow and synchronous, so an edge detector suffices.
        tcc_e   = timeout_count_clock_i & ~q.tcc_prev; // RULE9
        cylinder_over_range = bus_data_i[9:0] > fault_pkg::CYL_MAX; // RULE1
        head_bad = bus_data_i[11:8] > fault_pkg::HEAD_MAX; // RULE6
        sect_bad = bus_data_i[7:0] > fault_pkg::SECT_MAX; // RULE7
        seek_bad = seek_e & (cylinder_over_range | heads_settled_n_i); // RULE2
        seek_ok  = seek_e & ~seek_bad;
        nd_rst = interlock_clear_i | run_switch_i | cmd_i.clear_status_command
                 | q.sw_clear; // RULE5
        d_rst  = interlock_clear_i | run_switch_i; // RULE12
        gain_set = ~servo_gain_ok_i & q.drive_ready_flag & (q.seek_check_clear_pulse <= fault_pkg::CYL_MAX); // RULE15
        cb_set   = carriage_fully_back_i & q.drive_ready_flag; // RULE17
        ilk_bad  = ~(ilk_i.board_seated & ilk_i.chamber_connected & ilk_i.supply_good
                     & ilk_i.heatsink_ok) | ilk_i.spindle_fault; // RULE19
        trig = gain_set | cb_set | ilk_bad | q.to_f | q.gain_f | q.cb_f | q.ilk_f;
        full = q.to_f | q.ilk_f;
        unload_start = (q.seq == fault_pkg::SEQ_IDLE) & (trig | q.sw_unload);
        limit  = q.to_long ? LONG_LIM : SEEK_LIM; // RULE20
        cancel = q.to_act & (q.to_unload ? carriage_fully_back_i
                 : (~heads_settled_n_i & (~q.to_long | (q.seek_check_clear_pulse == '0)))); // RULE8 RULE10
        expire = q.to_act & ~q.to_f & ~cancel & (q.to_cnt >= limit); // RULE20
        status_w = '0;
        status_w[fault_pkg::ST_ILL_HEAD]  = q.ill_head;
        status_w[fault_pkg::ST_ILL_SECT]  = q.ill_sect;
        status_w[fault_pkg::ST_SEEK_CHK]  = q.seek_chk | q.ill_head | q.ill_sect; // RULE3
        status_w[fault_pkg::ST_CYL_OVER]  = cylinder_over_range;
        status_w[fault_pkg::ST_DRV_FAULT] = q.gain_f | q.cb_f | q.to_f | q.ilk_f; // RULE13
        status_w[fault_pkg::ST_GAIN]      = q.gain_f;
        status_w[fault_pkg::ST_CARR_BACK] = q.cb_f;
        status_w[fault_pkg::ST_TIMEOUT]   = q.to_f;
        status_w[fault_pkg::ST_INTERLOCK] = q.ilk_f;
        status_w[fault_pkg::ST_READY]     = q.drive_ready_flag;
        status_w[fault_pkg::ST_TIMING]    = q.to_act;
        addr_w = '0;
        addr_w[9:0] = q.seek_check_clear_pulse;
        addr_w[fault_pkg::AD_HEAD_LSB +: 4] = q.head;
        addr_w[fault_pkg::AD_SECT_LSB +: 8] = q.sector;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.cmd_prev = cmd_i;
        d.tcc_prev = timeout_count_clock_i;
        d.sw_clear = 1'b0;
        d.sw_unload = 1'b0;

        // Offending addresses never reach their registers.
        if (seek_ok) begin
            d.seek_check_clear_pulse = bus_data_i[9:0]; // RULE1
        end
        if (~cmd_i.home_seek_n) begin
            d.seek_check_clear_pulse = '0;
        end
        if (addr_e && !head_bad) begin
            d.head = bus_data_i[11:8]; // RULE6
        end
        if (sect_e && !sect_bad) begin
            d.sector = bus_data_i[7:0]; // RULE7
        end

        // A flag set in the same cycle as its clear stays set.
        d.seek_chk = seek_bad
                     | (q.seek_chk & ~nd_rst & ~seek_ok & cmd_i.home_seek_n); // RULE4
        d.ill_head = (addr_e & head_bad) | (q.ill_head & ~nd_rst); // RULE6
        d.ill_sect = (sect_e & sect_bad) | (q.ill_sect & ~nd_rst); // RULE7
        d.gain_f = gain_set | (q.gain_f & ~nd_rst); // RULE16
        d.cb_f   = cb_set | (q.cb_f & ~d_rst); // RULE18
        d.ilk_f  = ilk_bad | (q.ilk_f & ~d_rst);
        d.to_f   = expire | (q.to_f & ~d_rst); // RULE12

        // Once timed out the counter is frozen until a destructive reset.
        if (!q.to_f) begin
            if (tcc_e && q.to_act) begin
                d.to_cnt = q.to_cnt + 1'b1; // RULE9
            end
            if (cancel || expire) begin
                d.to_act = 1'b0;
            end
            if (seek_ok || home_e || recal_e || unload_start) begin
                d.to_act    = 1'b1; // RULE8 RULE10
                d.to_cnt    = '0; // RULE20
                d.to_long   = ~seek_ok | home_e | recal_e | unload_start;
                d.to_unload = unload_start;
            end
        end else if (d_rst) begin
            d.to_act = 1'b0; // RULE12
            d.to_cnt = '0;
        end

        if (cancel && q.to_long && !q.to_unload && !trig
            && q.seq == fault_pkg::SEQ_IDLE) begin
            d.drive_ready_flag     = 1'b1;
            d.servo_en = 1'b1;
        end

        unique case (q.seq)
            fault_pkg::SEQ_IDLE: begin
                if (unload_start) begin
                    d.seq      = fault_pkg::SEQ_RETRACT; // RULE13
                    d.drive_ready_flag     = 1'b0;
                    d.servo_en = 1'b0;
                end
            end
            fault_pkg::SEQ_RETRACT: begin
                if (carriage_fully_back_i) begin
                    d.seq = full ? fault_pkg::SEQ_BRAKE : fault_pkg::SEQ_HELD; // RULE14
                end
            end
            fault_pkg::SEQ_HELD: begin
                if (full) begin
                    d.seq = fault_pkg::SEQ_BRAKE; // RULE11
                end
            end
            fault_pkg::SEQ_BRAKE: begin
                if (!spindle_turning_n_i) begin
                    d.seq = fault_pkg::SEQ_UNLOCK; // RULE14
                end
            end
            fault_pkg::SEQ_UNLOCK: begin
                d.seq = fault_pkg::SEQ_UNLOCK;
            end
        endcase
        // The heads stay parked until a destructive reset restarts the drive.
        if (d_rst && !trig && q.seq != fault_pkg::SEQ_RETRACT) begin
            d.seq = fault_pkg::SEQ_IDLE;
        end

        // Register bus, write side.
        if (s_axi_awvalid && q.awready) begin
            d.awready = 1'b0;
            d.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.wready = 1'b0;
            d.wdata  = s_axi_wdata[1:0];
            d.wstb   = s_axi_wstrb[0];
        end
        if (!q.awready && !q.wready && !q.bvalid) begin
            d.bvalid = 1'b1;
            d.bresp  = (reg_sel(q.waddr) == 2'h3) ? fault_pkg::RESP_SLVERR
                                                    : fault_pkg::RESP_OKAY;
            if (reg_sel(q.waddr) == 2'h2 && q.wstb) begin
                d.sw_clear  = q.wdata[fault_pkg::CTRL_CLEAR];
                d.sw_unload = q.wdata[fault_pkg::CTRL_UNLOAD];
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end

        // Register bus, read side.
        if (s_axi_arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = fault_pkg::RESP_OKAY;
            unique case (reg_sel(s_axi_araddr))
                2'h0: d.rdata = {16'h0000, status_w};
                2'h1: d.rdata = addr_w;
                2'h2: d.rdata = 32'h0000_0000;
                2'h3: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = fault_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        // Indicators follow the next state so that every output is a flop.
        d.ind.timeout_fault_indicator_n = ~d.to_f; // RULE11
        d.ind.drive_fault_lamp_n = ~(d.gain_f | d.cb_f | d.to_f | d.ilk_f); // RULE13
        d.ind.ready_lamp_n       = ~d.drive_ready_flag;
        d.ind.servo_enable_n     = ~d.servo_en;
        d.ind.head_retract       = d.seq != fault_pkg::SEQ_IDLE;
        d.ind.spindle_stop_n     = ~(d.seq == fault_pkg::SEQ_BRAKE
                                     || d.seq == fault_pkg::SEQ_UNLOCK); // RULE14
        d.ind.door_unlock        = d.seq == fault_pkg::SEQ_UNLOCK;
        d.ind.door_unlocked_lamp_n = ~(d.seq == fault_pkg::SEQ_UNLOCK);
        d.ind.gain_fault_indicator_n    = ~d.gain_f; // RULE15
        d.ind.carriage_back_indicator_n = ~d.cb_f; // RULE17
        d.ind.interlock_lamp_n   = ~d.ilk_f;
        d.ind.seek_check         = d.seek_chk | d.ill_head | d.ill_sect;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= fault_pkg::STATE_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign ind_o         = q.ind;
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = q.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Checks assume the clock enable stays high across their span.
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || !ce_i);

    sequence s_fault_seen;
        q.seq == fault_pkg::SEQ_IDLE && trig;
    endsequence

    sequence s_parked;
        ind_o.head_retract && ind_o.servo_enable_n && ind_o.ready_lamp_n;
    endsequence

    a_cyl_guard: assert property (seek_e && cylinder_over_range && ~cmd_i.home_seek_n == 1'b0
        |=> q.seek_check_clear_pulse == $past(q.seek_check_clear_pulse) && q.seek_chk) // RULE1
        else $error("Out of range cylinder was loaded.");
    a_seek_overlap: assert property (seek_e && heads_settled_n_i
        |=> ind_o.seek_check) // RULE2
        else $error("Overlapping seek not flagged.");
    a_head_guard: assert property (addr_e && head_bad
        |=> q.head == $past(q.head) && status_w[fault_pkg::ST_SEEK_CHK]) // RULE3
        else $error("Illegal head not reported.");
    a_seek_clear: assert property (!cmd_i.home_seek_n && !seek_bad
        |=> !q.seek_chk) // RULE4
        else $error("Home seek left seek check set.");
    a_gain_clear: assert property (cmd_i.clear_status_command && !gain_set
        |=> !q.gain_f && ind_o.gain_fault_indicator_n) // RULE16
        else $error("Clear status kept gain fault.");
    a_sect_guard: assert property (sect_e && sect_bad
        |=> q.ill_sect && q.sector == $past(q.sector)) // RULE7
        else $error("Illegal sector not guarded.");
    a_seek_timer: assert property (seek_ok && !q.to_f && !unload_start
        |=> q.to_act && q.to_cnt == '0 && !q.to_long) // RULE8
        else $error("Seek did not start the short timeout.");
    a_timeout_fire: assert property (expire
        |=> q.to_f && !ind_o.timeout_fault_indicator_n && !ind_o.drive_fault_lamp_n) // RULE11
        else $error("Timeout expiry not indicated.");
    a_timer_hold: assert property (q.to_f && !d_rst |=> $stable(q.to_cnt) && q.to_f) // RULE12
        else $error("Timed out counter moved.");
    a_cb_set: assert property (cb_set
        |=> q.cb_f && !ind_o.carriage_back_indicator_n) // RULE17
        else $error("Carriage back fault missed.");
    a_cb_keep: assert property (q.cb_f && !d_rst |=> q.cb_f) // RULE18
        else $error("Carriage back fault cleared early.");
    a_interlock_set: assert property (ilk_bad |=> q.ilk_f && !ind_o.interlock_lamp_n) // RULE19
        else $error("Interlock fault missed.");
    a_unload_order: assert property (s_fault_seen |=> s_parked) // RULE13
        else $error("Fault did not start the unload.");
    a_brake_step: assert property (q.seq == fault_pkg::SEQ_RETRACT
        && carriage_fully_back_i && full && !d_rst
        |=> !ind_o.spindle_stop_n && ind_o.door_unlocked_lamp_n) // RULE14
        else $error("Spindle not stopped after retract.");

endmodule

// ### test/disc_ctl_model.sv
// Behavioural disc controller issuing commands on the internal control bus.
module disc_ctl_model (
    // Clock
    input  wire logic       clk_i,
    // Control bus
    output fault_pkg::cmd_t cmd_o,
    output logic [15:0]     bus_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_o = fault_pkg::CMD_RST;
        bus_data_o = 16'h0000;
    end
    // Released data is inverted so a stale value never looks like fresh data.
    // A strobe leaves its idle level for one cycle, so active-low commands work too.
    task automatic issue(input int b, input logic [15:0] d);
        @(posedge clk_i);
        cmd_o[b] <= ~fault_pkg::CMD_RST[b];
        bus_data_o <= d;
        @(posedge clk_i);
        cmd_o[b] <= fault_pkg::CMD_RST[b];
        bus_data_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the disc fault supervisor.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, timeout_count_clock = 1'b0, carriage_fully_back = 1'b0, spd_n = 1'b1, stl_n = 1'b0;
    logic gok = 1'b1, ilc = 1'b0;
    logic run = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rd_d;
    logic [1:0]  resp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] bus;
    fault_pkg::cmd_t cmd;
    fault_pkg::ind_t ind;
    int miscompares = 0, checked = 0;
    always #5 clk_i = ~clk_i;
    disc_ctl_model ctl (.clk_i(clk_i), .cmd_o(cmd), .bus_data_o(bus));
    disc_fault_supervisor #(.SEEK_MS(15), .LONG_MS(30)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(1'b1), .cmd_i(cmd), .bus_data_i(bus), .heads_settled_n_i(stl_n),
        .timeout_count_clock_i(timeout_count_clock), .servo_gain_ok_i(gok), .carriage_fully_back_i(carriage_fully_back),
        .spindle_turning_n_i(spd_n), .interlock_clear_i(ilc), .run_switch_i(run),
        .ilk_i(5'h1e), .ind_o(ind), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, b;
        @(posedge clk_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            #1 ta = awvalid & awready; tw = wvalid & wready; b = bvalid; resp = bresp;
            @(posedge clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        logic t, v;
        @(posedge clk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            #1 t = arvalid & arready; v = rvalid; rd_d = rdata; resp = rresp;
            @(posedge clk_i);
            if (t) arvalid <= 1'b0;
        end while (!v);
        rready <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(5'h00);
        chk(rd_d, 32'h0);
        ctl.issue(4, 16'h0909);
        rd(5'h00);
        chk(rd_d, 32'h5);
        rd(5'h04);
        chk(rd_d, 32'h0900_0000);
        ctl.issue(3, 16'h0040);
        rd(5'h00);
        chk(rd_d, 32'hf);
        ctl.issue(1, 16'h0040);
        rd(5'h00);
        chk(rd_d, 32'h8);
        ctl.issue(5, 16'h0337);
        rd(5'h00);
        chk(rd_d, 32'h4);
        ctl.issue(0, 16'h0000);
        rd(5'h00);
        chk(rd_d, 32'h208);
        ctl.issue(5, 16'h0100);
        rd(5'h04);
        chk(rd_d, 32'h0900_0100);
        rd(5'h0c);
        chk({30'h0, resp}, 32'h2);
        wr(5'h10, 32'h0);
        chk({30'h0, resp}, 32'h2);
        fork
            ctl.issue(5, 16'h0020);
            begin
                repeat (2) @(posedge clk_i);
                stl_n <= 1'b1;
            end
        join
        ctl.issue(5, 16'h0040);
        repeat (3) begin
            timeout_count_clock <= 1'b1;
            repeat (2) @(posedge clk_i);
            timeout_count_clock <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        rd(5'h00);
        chk(rd_d & 32'h94, 32'h94);
        chk({ind.timeout_fault_indicator_n, ind.head_retract, ind.servo_enable_n}, 32'h3);
        wr(5'h08, 32'h1);
        rd(5'h00);
        chk(rd_d & 32'h84, 32'h80);
        carriage_fully_back <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({ind.spindle_stop_n, ind.door_unlock}, 32'h0);
        spd_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({ind.door_unlock, ind.door_unlocked_lamp_n}, 32'h2);
        run <= 1'b1;
        @(posedge clk_i);
        run <= 1'b0;
        rd(5'h00);
        chk(rd_d & 32'h84, 32'h0);
        complete_run();
    end
endmodule
